// File: rtl/ocd_shaper.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Primary high time in half synthesizer cycles.
// - Divide below two ignores width and secondary.
// - Secondary period counts divided output cycles.
// - Secondary width counts half output periods.
// - Phase offset is signed half-cycle count.
// - Positive offset delays, negative offset advances.
// - Divide of one passes synthesizer clock through.
module ocd_shaper import ocd_pkg::*; #(
  parameter int CW = 32 // Counter and register width
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata_q,
  output logic [1:0]       clk_p_q,
  output logic [1:0]       clk_n_q
);
  localparam int PW = CW + 3; // Signed half-cycle position width
  // Two bits of headroom hold twice the divide count and the sign; a
  // third keeps a full-range phase change from wrapping the position.

  // ---------------------------------------------------------------
  // Software-visible settings
  // ---------------------------------------------------------------
  logic [CW-1:0] div_q;   // Programmed divide count
  logic [CW-1:0] wid_q;   // Programmed high time
  logic [CW-1:0] eper_q;  // Programmed secondary period
  logic [CW-1:0] ewid_q;  // Programmed secondary high time
  logic [CW-1:0] ph_q;    // Programmed phase offset
  logic          neg_q;   // Programmed negative-leg mode

  // ---------------------------------------------------------------
  // Applied settings, loaded only at boundaries
  // ---------------------------------------------------------------
  logic [CW-1:0] div_a_q;
  logic [CW-1:0] wid_a_q;
  logic [CW-1:0] eper_a_q;
  logic [CW-1:0] ewid_a_q;
  logic [CW-1:0] ph_a_q;
  logic          neg_a_q;

  // ---------------------------------------------------------------
  // Waveform state
  // ---------------------------------------------------------------
  logic signed [PW-1:0] pos_q;   // Half-cycle position in output period
  logic signed [PW-1:0] pos_d;
  logic [CW-1:0]        k_q;     // Output period index in secondary period
  logic [CW-1:0]        k_d;

  // Derived terms
  logic                 byp;      // Applied divide count below two
  logic                 bound;    // Last synthesizer cycle of this period
  logic                 k_wrap;   // Last output period of secondary period
  logic signed [PW-1:0] two_div;  // Period length in half cycles
  logic signed [PW-1:0] div_s;    // Half a period in half cycles
  logic signed [PW-1:0] wid_s;
  logic signed [PW-1:0] ewid_s;
  logic signed [PW-1:0] delta;    // Phase change still to apply
  logic signed [PW-1:0] pos1;     // Second half slot position
  logic signed [PW-1:0] kk;       // Secondary half-period index base
  logic [1:0]           p_pat;
  logic [1:0]           n_pat;

  // ---------------------------------------------------------------
  // Register write port
  // ---------------------------------------------------------------
  // No wait states: a strobe is taken at the edge that samples it
  // Settings registers; writes land at once, use waits for boundary
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_q  <= CW'(OCD_DIV_RST);
      wid_q  <= CW'(OCD_WID_RST);
      eper_q <= CW'(OCD_EPER_RST);
      ewid_q <= CW'(OCD_EWID_RST);
      ph_q   <= CW'(OCD_PHASE_RST);
      neg_q  <= OCD_NEG_RST;
    end else if (ce && wr_en) begin
      case (addr)
        OCD_DIV_ADDR:   div_q  <= CW'(wdata);
        OCD_WID_ADDR:   wid_q  <= CW'(wdata);
        OCD_EPER_ADDR:  eper_q <= CW'(wdata);
        OCD_EWID_ADDR:  ewid_q <= CW'(wdata);
        OCD_PHASE_ADDR: ph_q   <= CW'(wdata);
        OCD_CTRL_ADDR:  neg_q  <= wdata[OCD_CTRL_NEG_BIT];
        default: begin
          // Unmapped and read-only addresses ignore writes
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Read data valid in the cycle after the strobe only
  // Zero between reads keeps a stale word off the bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= 32'h0000_0000;
      if (rd_en) begin
        case (addr)
          OCD_DIV_ADDR:   rdata_q <= 32'(div_q);
          OCD_WID_ADDR:   rdata_q <= 32'(wid_q);
          OCD_EPER_ADDR:  rdata_q <= 32'(eper_q);
          OCD_EWID_ADDR:  rdata_q <= 32'(ewid_q);
          OCD_PHASE_ADDR: rdata_q <= 32'(ph_q);
          OCD_CTRL_ADDR:  rdata_q[OCD_CTRL_NEG_BIT] <= neg_q;
          OCD_STAT_ADDR: begin
            // Applied state, so software can see when a change took hold
            rdata_q[OCD_STAT_BYP_BIT]  <= byp;
            rdata_q[OCD_STAT_NEG_BIT]  <= neg_a_q;
            rdata_q[OCD_STAT_PEND_BIT] <= (div_q != div_a_q) || (wid_q != wid_a_q) || (ph_q != ph_a_q);
            rdata_q[OCD_STAT_DLY_BIT]  <= pos_q < 0;
          end
          default: begin
            // Unmapped reads return zero
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Period arithmetic
  // ---------------------------------------------------------------
  // Position compares in signed half-cycle units so a delay gap is negative
  // Divide zero falls into bypass, a safe choice for an undefined count
  always_comb begin
    byp     = div_a_q < CW'(OCD_MIN_DIV);
    two_div = $signed({2'b00, div_a_q, 1'b0});
    div_s   = $signed({3'b000, div_a_q});
    wid_s   = $signed({3'b000, wid_a_q});
    ewid_s  = $signed({3'b000, ewid_a_q});
    delta   = $signed({{3{ph_q[CW-1]}}, ph_q}) - $signed({{3{ph_a_q[CW-1]}}, ph_a_q});
    bound   = byp || (pos_q + PW'(2) >= two_div);
    k_wrap  = (k_q + CW'(1)) >= eper_a_q;
    kk      = $signed({2'b00, k_q, 1'b0});
  end

  // Next position: a positive change pushes the restart below zero,
  // which holds the output low for that many half cycles; a negative
  // change restarts part way into the period. Advances should stay
  // below one period, larger ones are taken one period per boundary.
  always_comb begin
    pos_d = pos_q + PW'(2);
    if (byp) begin
      pos_d = '0;
    end else if (bound) begin
      pos_d = pos_q + PW'(2) - two_div - delta;
    end
    // Second half slot; after an odd shift it crosses the boundary and
    // then opens the next period, one half slot before its first cycle
    pos1 = pos_q + PW'(1);
    if (!byp && bound && (pos1 >= two_div)) begin
      pos1 = pos_d - PW'(1);
    end
  end

  // Secondary period index advances once per output period
  // Kept at zero in bypass so the secondary restarts cleanly
  always_comb begin
    k_d = k_q;
    if (byp) begin
      k_d = '0;
    end else if (bound) begin
      k_d = k_wrap ? '0 : k_q + CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Applied settings
  // ---------------------------------------------------------------
  // Loading only at the boundary keeps every pulse whole
  // Limitation: an advance still cuts the pulse it lands in
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_a_q <= CW'(OCD_DIV_RST);
      wid_a_q <= CW'(OCD_WID_RST);
      ph_a_q  <= CW'(OCD_PHASE_RST);
      neg_a_q <= OCD_NEG_RST;
    end else if (ce && bound) begin
      div_a_q <= div_q;
      wid_a_q <= wid_q;
      ph_a_q  <= ph_q;
      neg_a_q <= neg_q;
    end
  end

  // Secondary settings change only at a secondary period end or in bypass
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eper_a_q <= CW'(OCD_EPER_RST);
      ewid_a_q <= CW'(OCD_EWID_RST);
    end else if (ce && (byp || (bound && k_wrap))) begin
      eper_a_q <= eper_q;
      ewid_a_q <= ewid_q;
    end
  end

  // Position and secondary index
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pos_q <= '0;
      k_q   <= '0;
    end else if (ce) begin
      pos_q <= pos_d;
      k_q   <= k_d;
    end
  end

  // ---------------------------------------------------------------
  // Output patterns
  // ---------------------------------------------------------------
  // Each half slot is high while its position is below the high time
  // Gap slots have negative positions and so read low
  always_comb begin
    p_pat = OCD_PAT_LOW;
    n_pat = OCD_PAT_LOW;
    if (byp) begin
      p_pat = OCD_PAT_CLK;
      n_pat = OCD_PAT_NCLK;
    end else begin
      p_pat[1] = (pos_q >= 0) && (pos_q < wid_s);
      p_pat[0] = (pos1 >= 0) && (pos1 < wid_s);
      if (neg_a_q) begin
        // Offset assumed zero here, so the gap case is simply low
        n_pat[1] = (pos_q >= 0) && ((kk + PW'(pos_q >= div_s)) < ewid_s);
        n_pat[0] = (pos1 >= 0) && ((kk + PW'(pos1 >= div_s)) < ewid_s);
      end else begin
        n_pat = ~p_pat;
      end
    end
  end

  // Registered pins, one cycle behind the position
  // Flopped so the pins never show a combinational glitch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_p_q <= OCD_PAT_LOW;
      clk_n_q <= OCD_PAT_LOW;
    end else if (ce) begin
      clk_p_q <= p_pat;
      clk_n_q <= n_pat;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking ocd_cb @(posedge mclk); endclocking
  default disable iff (rst);

  bypass_out_a: assert property (ce && byp |=> clk_p_q == OCD_PAT_CLK)
    else $error("bypass did not pass synthesizer clock");
  ignore_width_a: assert property (ce && byp |=> clk_n_q == OCD_PAT_NCLK)
    else $error("secondary not ignored in bypass");
  // Properties watch the registered pins one cycle after the state
  // that sets them; a low enable in between is not modelled
  width_high_a: assert property (ce && !byp && pos_q >= 0 && pos_q < wid_s && pos1 >= 0
                                 && pos1 < wid_s |=> clk_p_q == OCD_PAT_HIGH)
    else $error("output low inside high time");
  width_low_a: assert property (ce && !byp && pos_q >= wid_s && pos1 >= wid_s |=> clk_p_q == OCD_PAT_LOW)
    else $error("output high past high time");
  wrap_first_a: assert property (ce && !byp && bound && pos_q >= wid_s && pos1 >= 0 && pos1 < wid_s
                                 |=> clk_p_q == 2'h1)
    else $error("first half slot of period lost");
  apply_bound_a: assert property (ce && !bound |=> $stable(div_a_q) && $stable(wid_a_q) && $stable(ph_a_q))
    else $error("setting applied mid period");
  phase_delay_a: assert property (ce && bound && !byp && pos_q >= 0 && pos_q < two_div && delta > 2
                                  |=> pos_q < 0 ##1 clk_p_q == OCD_PAT_LOW)
    else $error("positive offset did not delay");
  phase_adv_a: assert property (ce && bound && !byp && pos_q >= 0 && pos_q < two_div && delta < 0
                                |=> pos_q > 0)
    else $error("negative offset did not advance");
  esync_wrap_a: assert property (ce && bound && !byp && k_wrap |=> k_q == '0)
    else $error("secondary period did not wrap");
  esync_width_a: assert property (ce && !byp && neg_a_q && k_q == '0 && pos_q >= 0 && pos1 < div_s
                                  && ewid_a_q != '0 |=> clk_n_q == OCD_PAT_HIGH)
    else $error("secondary low inside its high time");
  esync_low_a: assert property (ce && !byp && neg_a_q && pos_q >= 0 && pos1 >= 0 && kk >= ewid_s
                                |=> clk_n_q == OCD_PAT_LOW)
    else $error("secondary high past its high time");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  bypass_c: cover property (ce && byp ##1 ce && !byp);
  delay_c:  cover property (ce && pos_q < 0);
  esync_c:  cover property (ce && neg_a_q && bound && k_wrap);
  adv_c:    cover property (ce && bound && !byp && delta < 0);
  odd_c:    cover property (ce && bound && !byp && pos1 < pos_q);
endmodule

// File: pkg/ocd_pkg.sv
package ocd_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OCD_DIV_ADDR   = 12'h70c; // Output divide count
  localparam logic [11:0] OCD_WID_ADDR   = 12'h710; // pulse_high_time
  localparam logic [11:0] OCD_EPER_ADDR  = 12'h714; // secondary_leg_period
  localparam logic [11:0] OCD_EWID_ADDR  = 12'h718; // secondary_leg_high_time
  localparam logic [11:0] OCD_PHASE_ADDR = 12'h720; // edge_phase_offset
  localparam logic [11:0] OCD_CTRL_ADDR  = 12'h740; // Control: negative-leg mode
  localparam logic [11:0] OCD_STAT_ADDR  = 12'h744; // Status: applied state

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] OCD_DIV_RST   = 32'h0000_0002;
  localparam logic [31:0] OCD_WID_RST   = 32'h0000_0002;
  localparam logic [31:0] OCD_EPER_RST  = 32'h0000_0002;
  localparam logic [31:0] OCD_EWID_RST  = 32'h0000_0002;
  localparam logic [31:0] OCD_PHASE_RST = 32'h0000_0000;
  localparam logic        OCD_NEG_RST   = 1'b0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OCD_CTRL_NEG_BIT  = 0; // Negative-leg divided mode select
  localparam int OCD_STAT_BYP_BIT  = 0; // Applied divide count below two
  localparam int OCD_STAT_NEG_BIT  = 1; // Applied negative-leg mode
  localparam int OCD_STAT_PEND_BIT = 2; // Divide, width or phase waiting for boundary
  localparam int OCD_STAT_DLY_BIT  = 3; // Inside a phase delay gap

  // ---------------------------------------------------------------
  // Output half-cycle patterns: bit 1 first half, bit 0 second half
  // ---------------------------------------------------------------
  localparam logic [1:0] OCD_PAT_CLK  = 2'h2; // Synthesizer clock itself
  localparam logic [1:0] OCD_PAT_NCLK = 2'h1; // Its complement
  localparam logic [1:0] OCD_PAT_LOW  = 2'h0;
  localparam logic [1:0] OCD_PAT_HIGH = 2'h3;
  localparam logic [1:0] OCD_MIN_DIV  = 2'h2; // Below this the divider is bypassed
endpackage

// File: bench/ocd_rx_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Clock receiver on both output legs
// ---------------------------------------------------------------
// Counts high half slots and rising edges while meas is high, and
// keeps the half index of the latest primary rising edge.
// Counts over whole periods make the result independent of alignment.
module ocd_rx_model (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             meas,
  input  wire logic [1:0]       clk_p_q,
  input  wire logic [1:0]       clk_n_q,
  output logic      [1:0][15:0] hi_q,
  output logic      [1:0][15:0] rise_q,
  output logic      [31:0]      rise_at_q
);
  logic [1:0][1:0] slot; // Index 0 primary, 1 negative leg
  logic [1:0]      prev_q; // Last half slot of previous cycle
  logic [31:0]     hc_q; // Half slot counter since reset
  assign slot = {clk_n_q, clk_p_q};

  // Edge and level counting per leg
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_q <= '0;
      rise_q <= '0;
      prev_q <= '0;
      hc_q <= '0;
      rise_at_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        prev_q[i] <= slot[i][0];
        if (meas) begin
          hi_q[i] <= hi_q[i] + 16'(slot[i][1]) + 16'(slot[i][0]);
          rise_q[i] <= rise_q[i] + 16'(slot[i][1] & ~prev_q[i]) + 16'(slot[i][0] & ~slot[i][1]);
        end else begin
          hi_q[i] <= '0;
          rise_q[i] <= '0;
        end
      end
      hc_q <= hc_q + 32'h2;
      // Second half edge wins, it is the later one
      if (slot[0][0] & ~slot[0][1]) begin
        rise_at_q <= hc_q + 32'h1;
      end else if (slot[0][1] & ~prev_q[0]) begin
        rise_at_q <= hc_q;
      end
    end
  end
endmodule

// File: bench/output_clock_divider_shaper_tb_top.sv
`timescale 1ns/1ps
module output_clock_divider_shaper_tb_top import ocd_pkg::*;;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic             mclk, rst, ce, wr_en, rd_en, meas;
  logic [11:0]      addr;
  logic [31:0]      wdata, rdata_q, rise_at, d;
  logic [1:0]       clk_p_q, clk_n_q;
  logic [1:0][15:0] hi, rise;
  int               n_mismatch, check_count;
  logic [11:0]      ra [6] = '{OCD_DIV_ADDR, OCD_WID_ADDR, OCD_EPER_ADDR, OCD_EWID_ADDR, OCD_PHASE_ADDR, OCD_CTRL_ADDR};

  ocd_shaper u_dut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .clk_p_q(clk_p_q), .clk_n_q(clk_n_q));
  ocd_rx_model u_rx (.mclk(mclk), .rst(rst), .meas(meas), .clk_p_q(clk_p_q), .clk_n_q(clk_n_q),
    .hi_q(hi), .rise_q(rise), .rise_at_q(rise_at));

  // 25 MHz synthesizer clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr_en <= 1'b1; addr <= a; wdata <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge mclk);
    rd_en <= 1'b1; addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rdata_q;
  endtask
  // Write all settings, read them back, then wait past the boundaries
  task automatic cfg(input logic [31:0] v [6]);
    for (int i = 0; i < 6; i++) wr(ra[i], v[i]);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(d, v[i], "readback");
    end
    repeat (60) @(posedge mclk);
  endtask
  // Window of w cycles, compared against half slot counts
  task automatic measure(input string nm, input int w, input logic [15:0] ph, pr, nh, nr);
    @(posedge mclk) meas <= 1'b1;
    repeat (w) @(posedge mclk);
    meas <= 1'b0;
    #1 chk(hi[0], ph, "p high");
    chk(rise[0], pr, "p rise");
    chk(hi[1], nh, "n high");
    chk(rise[1], nr, "n rise");
    $display("test %s done", nm);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog, runs well past the expected length of the tests
  initial begin
    repeat (6000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] rv [6];
    logic [31:0] ph_t [4];
    logic [2:0]  r, r0, sh [4];
    rv = '{OCD_DIV_RST, OCD_WID_RST, OCD_EPER_RST, OCD_EWID_RST, OCD_PHASE_RST, {31'h0, OCD_NEG_RST}};
    ph_t = '{32'h0, 32'h3, 32'h0, 32'hffff_fffe};
    sh = '{3'h0, 3'h3, 3'h5, 3'h6};
    r0 = 3'h0;
    rst = 1'b1; ce = 1'b1; wr_en = 1'b0; rd_en = 1'b0; meas = 1'b0; addr = '0; wdata = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      chk(d, rv[i], "reset value");
    end
    rd(12'h724, d);
    chk(d, 32'h0, "unmapped read");
    measure("defaults", 32, 16'd32, 16'd16, 16'd32, 16'd16);
    // Frozen enable ignores a write
    @(posedge mclk) ce <= 1'b0;
    wr(OCD_WID_ADDR, 32'h3);
    ce <= 1'b1;
    rd(OCD_WID_ADDR, d);
    chk(d, OCD_WID_RST, "frozen write");
    cfg('{32'h3, 32'h3, 32'h2, 32'h2, 32'h0, 32'h0});
    measure("width3", 30, 16'd30, 16'd10, 16'd30, 16'd10);
    cfg('{32'h3, 32'h5, 32'h2, 32'h2, 32'h0, 32'h0});
    measure("width max", 30, 16'd50, 16'd10, 16'd10, 16'd10);
    cfg('{32'h1, 32'h5, 32'h2, 32'h2, 32'h0, 32'h0});
    measure("bypass", 30, 16'd30, 16'd30, 16'd30, 16'd30);
    rd(OCD_STAT_ADDR, d);
    chk(d, 32'h1, "status bypass");
    // Negative-leg modes keep the offset at zero
    cfg('{32'h2, 32'h2, 32'h3, 32'h2, 32'h0, 32'h1});
    measure("second 3/2", 36, 16'd36, 16'd18, 16'd24, 16'd6);
    cfg('{32'h2, 32'h2, 32'h4, 32'h3, 32'h0, 32'h1});
    measure("second 4/3", 32, 16'd32, 16'd16, 16'd24, 16'd4);
    cfg('{32'h1, 32'h3, 32'h5, 32'h7, 32'h0, 32'h1});
    measure("second bypass", 30, 16'd30, 16'd30, 16'd30, 16'd30);
    rd(OCD_STAT_ADDR, d);
    chk(d, 32'h3, "status second bypass");
    // Phase steps in the plain mode, period of eight half slots
    cfg('{32'h4, 32'h4, 32'h2, 32'h2, 32'h0, 32'h0});
    for (int i = 0; i < 4; i++) begin
      wr(OCD_PHASE_ADDR, ph_t[i]);
      repeat (40) @(posedge mclk);
      r = rise_at[2:0];
      if (i > 0) chk({29'h0, 3'(r - r0)}, {29'h0, sh[i]}, "phase shift");
      r0 = r;
    end
    measure("phase", 32, 16'd32, 16'd8, 16'd32, 16'd8);
    final_report();
  end
endmodule
